// ### hdl/keypad_menu_params.svh
// constants for the front-panel unlock and clear menu
`ifndef KEYPAD_MENU_PARAMS_SVH
`define KEYPAD_MENU_PARAMS_SVH
`define CLK_HZ 40000000
`define HOLD_MS 1000
`define HOLD_CYCLES ((`CLK_HZ / 1000) * `HOLD_MS)
`define REPEAT_MS 100
`define REPEAT_CYCLES ((`CLK_HZ / 1000) * `REPEAT_MS)
`define DEBOUNCE_US 10000
`define DEBOUNCE_CYCLES ((`CLK_HZ / 1000000) * `DEBOUNCE_US)
`define CODE_DIGITS 16
`define LINE_DIGITS 8
`define DIGIT_MAX 4'hF
`define DIGIT_MIN 4'h0
`endif

// ### hdl/keypad_menu_pkg.sv
// types for the front-panel unlock and clear menu
package keypad_menu_pkg;
	typedef enum logic [3:0] {
		SCR_TOP,
		SCR_MENU,
		SCR_NO_CODE,
		SCR_CODE_ENTRY,
		SCR_UNLOCKED_MSG,
		SCR_WRONG_MSG,
		SCR_REENABLE,
		SCR_CLEAR_ASK,
		SCR_CLEAR_DONE,
		SCR_RUNNING_MSG
	} screen_type;
	typedef enum logic [1:0] {
		ITEM_UNLOCK,
		ITEM_CLEAR,
		ITEM_OTHER
	} menu_item_type;
	typedef enum logic [1:0] {
		LOCK_NONE,
		LOCK_ACTIVE,
		LOCK_CANCELLED
	} lock_state_type;
endpackage

// ### hdl/button_conditioner.sv
// debounce one button and produce press and repeat step pulses
`timescale 1ns/100ps
`default_nettype none
`include "keypad_menu_params.svh"
module button_conditioner #(
	parameter int DEBOUNCE = `DEBOUNCE_CYCLES,
	parameter int HOLD = `HOLD_CYCLES,
	parameter int REPEAT = `REPEAT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic raw_btn,
	output logic press,
	output logic step
);
	logic stable_r, stable_nxt;
	logic [31:0] db_cnt_r, db_cnt_nxt;
	logic [31:0] hold_cnt_r, hold_cnt_nxt;
	logic fast_r, fast_nxt;
	logic press_r, press_nxt;
	logic step_r, step_nxt;

	// debounce, then step once per press edge and at a fixed rate after the hold time
	always_comb begin
		stable_nxt = stable_r;
		db_cnt_nxt = db_cnt_r;
		hold_cnt_nxt = hold_cnt_r;
		fast_nxt = fast_r;
		press_nxt = 1'b0;
		step_nxt = 1'b0;
		if (raw_btn == stable_r) begin
			db_cnt_nxt = 32'h0;
		end else if (db_cnt_r >= 32'(DEBOUNCE - 1)) begin
			db_cnt_nxt = 32'h0;
			stable_nxt = raw_btn;
			hold_cnt_nxt = 32'h0;
			fast_nxt = 1'b0;
			if (raw_btn) begin
				press_nxt = 1'b1; // RULE18
				step_nxt = 1'b1;
			end
		end else begin
			db_cnt_nxt = db_cnt_r + 32'h1;
		end
		if (stable_r && stable_nxt) begin
			if (!fast_r && hold_cnt_r >= 32'(HOLD - 1)) begin
				fast_nxt = 1'b1;
				hold_cnt_nxt = 32'h0;
				step_nxt = 1'b1;
			end else if (fast_r && hold_cnt_r >= 32'(REPEAT - 1)) begin
				hold_cnt_nxt = 32'h0;
				step_nxt = 1'b1; // RULE18
			end else begin
				hold_cnt_nxt = hold_cnt_r + 32'h1;
			end
		end
	end

	// register the conditioner state
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			stable_r <= 1'b0;
			db_cnt_r <= 32'h0;
			hold_cnt_r <= 32'h0;
			fast_r <= 1'b0;
			press_r <= 1'b0;
			step_r <= 1'b0;
		end else begin
			stable_r <= stable_nxt;
			db_cnt_r <= db_cnt_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			fast_r <= fast_nxt;
			press_r <= press_nxt;
			step_r <= step_nxt;
		end
	end

	assign press = press_r;
	assign step = step_r;
endmodule
`default_nettype wire

// ### hdl/keypad_unlock_and_clear_menu.sv
// front-panel menu: unlock code entry, re-enable and clear-all
// Contract
// RULE1 - ok on unlock item shows status screen
// RULE2 - no code registered: esc returns menu
// RULE3 - esc on menu screen goes top
// RULE4 - sixteen digits two lines, eight one line
// RULE5 - minus decrements digit, held repeats fast
// RULE6 - plus increments digit, held repeats fast
// RULE7 - esc on leftmost digit returns menu
// RULE8 - esc elsewhere moves cursor left
// RULE9 - ok latches digit, cursor moves right
// RULE10 - ok on last digit compares, match unlocks
// RULE11 - mismatch keeps lock, esc restarts entry
// RULE12 - ok or esc on result returns menu
// RULE13 - cancelled lock: ok re-enables, plus/minus ignored
// RULE14 - esc at re-enable keeps cancelled state
// RULE15 - clear-all only when stopped, clears working areas
// RULE16 - inputs and file registers never cleared
// RULE17 - running: skip clear, message, back menu
// RULE18 - debounce buttons, fixed-rate repeat when held
`timescale 1ns/100ps
`default_nettype none
`include "keypad_menu_params.svh"
module keypad_unlock_and_clear_menu #(
	parameter int DEBOUNCE = `DEBOUNCE_CYCLES,
	parameter int HOLD = `HOLD_CYCLES,
	parameter int REPEAT = `REPEAT_CYCLES,
	parameter int DIGITS = `CODE_DIGITS
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic btn_esc,
	input wire logic btn_minus,
	input wire logic btn_plus,
	input wire logic btn_ok,
	input wire keypad_menu_pkg::menu_item_type menu_item,
	input wire logic code_registered,
	input wire logic code_is_16,
	input wire logic [4*DIGITS-1:0] stored_code,
	input wire logic plc_running,
	output keypad_menu_pkg::screen_type screen,
	output keypad_menu_pkg::lock_state_type lock_state,
	output logic [1:0] entry_lines,
	output logic [4:0] cursor_pos,
	output logic [3:0] cursor_digit,
	output logic [4*DIGITS-1:0] entered_code,
	output logic clear_pulse,
	output logic clear_outputs,
	output logic clear_aux_relays,
	output logic clear_states,
	output logic clear_timers,
	output logic clear_counters,
	output logic clear_data_regs,
	output logic clear_ext_regs,
	output logic clear_inputs,
	output logic clear_file_regs,
	output logic clear_extended_file_registers
);
	import keypad_menu_pkg::*;

	logic esc_p, ok_p, minus_s, plus_s;
	screen_type scr_r, scr_nxt;
	logic cancelled_r, cancelled_nxt;
	logic [4:0] pos_r, pos_nxt;
	logic [3:0] dig_r, dig_nxt;
	logic [4*DIGITS-1:0] code_r, code_nxt;
	logic clr_r, clr_nxt;
	logic [4:0] last_pos;

	// esc and ok act once per press edge, so only their press pulse is used
	button_conditioner #(
		.DEBOUNCE(DEBOUNCE),
		.HOLD(HOLD),
		.REPEAT(REPEAT)
	) u_esc (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.raw_btn(btn_esc),
		.press(esc_p),
		.step()
	);
	button_conditioner #(
		.DEBOUNCE(DEBOUNCE),
		.HOLD(HOLD),
		.REPEAT(REPEAT)
	) u_ok (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.raw_btn(btn_ok),
		.press(ok_p),
		.step()
	);
	// minus and plus also repeat while held, so they use the step pulse
	button_conditioner #(
		.DEBOUNCE(DEBOUNCE),
		.HOLD(HOLD),
		.REPEAT(REPEAT)
	) u_minus (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.raw_btn(btn_minus),
		.press(),
		.step(minus_s)
	);
	button_conditioner #(
		.DEBOUNCE(DEBOUNCE),
		.HOLD(HOLD),
		.REPEAT(REPEAT)
	) u_plus (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.raw_btn(btn_plus),
		.press(),
		.step(plus_s)
	);

	// lowest bit of a digit slot; the leftmost digit sits in the top nibble
	function automatic int slot_lsb(input logic [4:0] pos);
		return 4 * (DIGITS - 1 - int'(pos));
	endfunction

	// compare the whole long code, or the top eight entered digits against the short code
	function automatic logic code_matches(input logic [4*DIGITS-1:0] entered,
		input logic [4*DIGITS-1:0] stored, input logic long_code);
		logic match;
		if (long_code) begin
			match = (entered == stored);
		end else begin
			match = (entered[4*DIGITS-1 -: 4*`LINE_DIGITS] == stored[4*`LINE_DIGITS-1:0]);
		end
		return match;
	endfunction

	// last digit position for the registered code length
	function automatic logic [4:0] final_pos(input logic long_code);
		return long_code ? 5'(DIGITS - 1) : 5'(`LINE_DIGITS - 1);
	endfunction

	// code length picks the last digit position
	assign last_pos = final_pos(code_is_16);

	// screen sequencing, digit editing and lock state
	always_comb begin
		scr_nxt = scr_r;
		cancelled_nxt = cancelled_r;
		pos_nxt = pos_r;
		dig_nxt = dig_r;
		code_nxt = code_r;
		clr_nxt = 1'b0;
		if (!code_registered) begin
			cancelled_nxt = 1'b0;
		end
		case (scr_r)
			SCR_TOP: begin
				if (ok_p) begin
					scr_nxt = SCR_MENU;
				end
			end

			SCR_MENU: begin
				if (esc_p) begin
					scr_nxt = SCR_TOP; // RULE3
				end else if (ok_p && menu_item == ITEM_UNLOCK) begin
					pos_nxt = 5'h00;
					dig_nxt = `DIGIT_MIN;
					code_nxt = '0;
					if (!code_registered) begin
						scr_nxt = SCR_NO_CODE; // RULE1
					end else if (cancelled_r) begin
						scr_nxt = SCR_REENABLE; // RULE13
					end else begin
						scr_nxt = SCR_CODE_ENTRY;
					end
				end else if (ok_p && menu_item == ITEM_CLEAR) begin
					scr_nxt = SCR_CLEAR_ASK;
				end
			end

			SCR_NO_CODE: begin
				if (esc_p) begin
					scr_nxt = SCR_MENU; // RULE2
				end
			end

			SCR_CODE_ENTRY: begin
				if (esc_p) begin
					if (pos_r == 5'h00) begin
						scr_nxt = SCR_MENU; // RULE7
					end else begin
						pos_nxt = pos_r - 5'h01; // RULE8
						dig_nxt = `DIGIT_MIN;
					end
				end else if (ok_p) begin
					code_nxt[slot_lsb(pos_r) +: 4] = dig_r; // RULE9
					dig_nxt = `DIGIT_MIN;
					if (pos_r == last_pos) begin
						if (code_matches(code_nxt, stored_code, code_is_16)) begin
							cancelled_nxt = 1'b1; // RULE10
							scr_nxt = SCR_UNLOCKED_MSG;
						end else begin
							scr_nxt = SCR_WRONG_MSG; // RULE11
						end
					end else begin
						pos_nxt = pos_r + 5'h01;
					end
				end else if (minus_s && dig_r != `DIGIT_MIN) begin
					dig_nxt = dig_r - 4'h1; // RULE5
				end else if (plus_s && dig_r != `DIGIT_MAX) begin
					dig_nxt = dig_r + 4'h1; // RULE6
				end
			end

			SCR_UNLOCKED_MSG: begin
				if (ok_p || esc_p) begin
					scr_nxt = SCR_MENU; // RULE12
				end
			end

			SCR_WRONG_MSG: begin
				if (esc_p) begin
					scr_nxt = SCR_CODE_ENTRY; // RULE11
					pos_nxt = 5'h00;
					dig_nxt = `DIGIT_MIN;
					code_nxt = '0;
				end else if (ok_p) begin
					scr_nxt = SCR_MENU; // RULE12
				end
			end

			SCR_REENABLE: begin
				if (ok_p) begin
					cancelled_nxt = 1'b0; // RULE13
					scr_nxt = SCR_MENU;
				end else if (esc_p) begin
					scr_nxt = SCR_MENU; // RULE14
				end
			end

			SCR_CLEAR_ASK: begin
				if (esc_p) begin
					scr_nxt = SCR_MENU;
				end else if (ok_p) begin
					if (plc_running) begin
						scr_nxt = SCR_RUNNING_MSG; // RULE17
					end else begin
						clr_nxt = 1'b1; // RULE15
						scr_nxt = SCR_CLEAR_DONE;
					end
				end
			end

			SCR_CLEAR_DONE, SCR_RUNNING_MSG: begin
				if (ok_p || esc_p) begin
					scr_nxt = SCR_MENU; // RULE17
				end
			end

			default: begin
				scr_nxt = SCR_TOP;
			end
		endcase
	end

	// register menu state
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			scr_r <= SCR_TOP;
			cancelled_r <= 1'b0;
			pos_r <= 5'h00;
			dig_r <= 4'h0;
			code_r <= '0;
			clr_r <= 1'b0;
		end else begin
			scr_r <= scr_nxt;
			cancelled_r <= cancelled_nxt;
			pos_r <= pos_nxt;
			dig_r <= dig_nxt;
			code_r <= code_nxt;
			clr_r <= clr_nxt;
		end
	end

	// status toward display and device memory
	assign screen = scr_r;
	assign lock_state = !code_registered ? LOCK_NONE : (cancelled_r ? LOCK_CANCELLED : LOCK_ACTIVE);
	assign entry_lines = code_is_16 ? 2'h2 : 2'h1; // RULE4
	assign cursor_pos = pos_r;
	assign cursor_digit = dig_r;
	assign entered_code = code_r;
	assign clear_pulse = clr_r;

	// working areas clear together on the one-cycle pulse
	assign clear_outputs = clr_r; // RULE15
	assign clear_aux_relays = clr_r;
	assign clear_states = clr_r;
	assign clear_timers = clr_r;
	assign clear_counters = clr_r;
	assign clear_data_regs = clr_r;
	assign clear_ext_regs = clr_r;

	// inputs and file registers are never touched by clear-all
	assign clear_inputs = 1'b0; // RULE16
	assign clear_file_regs = 1'b0;
	assign clear_extended_file_registers = 1'b0;
endmodule
`default_nettype wire

// ### verif/keypad_menu_asserts.sv
// checker for the front-panel unlock and clear menu
`timescale 1ns/100ps
`default_nettype none
module keypad_menu_asserts
	import keypad_menu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic code_is_16,
	input wire logic plc_running,
	input wire screen_type screen,
	input wire lock_state_type lock_state,
	input wire logic [1:0] entry_lines,
	input wire logic [4:0] cursor_pos,
	input wire logic clear_pulse,
	input wire logic clear_outputs,
	input wire logic clear_aux_relays,
	input wire logic clear_states,
	input wire logic clear_timers,
	input wire logic clear_counters,
	input wire logic clear_data_regs,
	input wire logic clear_ext_regs,
	input wire logic clear_inputs,
	input wire logic clear_file_regs,
	input wire logic clear_extended_file_registers
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// screen layout and cursor range
	chk_lines_sel: assert property (entry_lines == (code_is_16 ? 2'h2 : 2'h1)) else $error("lines");
	chk_cursor_range: assert property (screen == SCR_CODE_ENTRY |-> cursor_pos < (code_is_16 ? 5'h10 : 5'h08))
		else $error("cursor");
	// lock status against result screens
	chk_no_code: assert property (screen == SCR_NO_CODE |-> lock_state == LOCK_NONE) else $error("nocode");
	chk_unlock_ok: assert property ($rose(screen == SCR_UNLOCKED_MSG) |-> ##[0:1] lock_state == LOCK_CANCELLED)
		else $error("unlock");
	chk_wrong_keep: assert property (screen == SCR_WRONG_MSG |-> lock_state == LOCK_ACTIVE) else $error("wrong");
	// clearing only when stopped, one cycle, right areas
	chk_clear_stop: assert property (clear_pulse |-> !$past(plc_running)) else $error("run clr");
	chk_clear_done: assert property ($rose(screen == SCR_CLEAR_DONE) |-> ##[0:1] clear_pulse) else $error("done");
	chk_clear_once: assert property (clear_pulse |=> !clear_pulse) else $error("pulse");
	chk_clear_set: assert property (clear_outputs == clear_pulse && clear_aux_relays == clear_pulse &&
		clear_states == clear_pulse && clear_timers == clear_pulse && clear_counters == clear_pulse &&
		clear_data_regs == clear_pulse && clear_ext_regs == clear_pulse) else $error("set");
	chk_keep_inputs: assert property (!(clear_inputs | clear_file_regs | clear_extended_file_registers))
		else $error("keep");
	chk_run_msg: assert property ($rose(screen == SCR_RUNNING_MSG) |->
		$past(screen) == SCR_CLEAR_ASK && $past(plc_running)) else $error("runmsg");
	// main scenarios reached
	cov_unlock: cover property (screen == SCR_UNLOCKED_MSG);
	cov_wrong: cover property (screen == SCR_WRONG_MSG);
	cov_clear: cover property (clear_pulse);
	cov_reenable: cover property (screen == SCR_REENABLE);
endmodule
bind keypad_unlock_and_clear_menu keypad_menu_asserts chk (.*);
`default_nettype wire

// ### verif/keypad_operator.sv
// operator model pressing the four front-panel buttons
`timescale 1ns/100ps
`default_nettype none
module keypad_operator (
	input wire logic clk_sys,
	output logic btn_esc,
	output logic btn_minus,
	output logic btn_plus,
	output logic btn_ok
);
	logic [3:0] b = 4'h0;
	assign {btn_esc, btn_minus, btn_plus, btn_ok} = b;
	// hold one button n cycles, then stay idle so release settles
	task automatic push(input int k, input int n);
		@(negedge clk_sys) b[k] = 1'b1;
		repeat (n) @(negedge clk_sys);
		b[k] = 1'b0;
		repeat (8) @(negedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ### verif/keypad_unlock_and_clear_menu_tb.sv
// self-checking bench for the front-panel unlock and clear menu
`timescale 1ns/100ps
`default_nettype none
module keypad_unlock_and_clear_menu_tb;
	import keypad_menu_pkg::*;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t mismatch", $time); end end
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic btn_esc, btn_minus, btn_plus, btn_ok;
	menu_item_type menu_item = ITEM_UNLOCK;
	logic code_registered = 1'b0;
	logic code_is_16 = 1'b1;
	logic [63:0] stored_code = 64'h0;
	logic plc_running = 1'b0;
	screen_type screen;
	lock_state_type lock_state;
	logic [1:0] entry_lines;
	logic [4:0] cursor_pos;
	logic [3:0] cursor_digit;
	logic [63:0] entered_code;
	logic clear_pulse;
	int failures = 0;
	int checks = 0;
	int pulses = 0;
	int cyc = 0;
	int q[$];
	// short button timings keep the run brief
	localparam int DEB_T = 2;
	localparam int HOLD_T = 20;
	localparam int REPEAT_T = 5;
	keypad_operator op (.clk_sys(clk_sys), .btn_esc(btn_esc), .btn_minus(btn_minus), .btn_plus(btn_plus),
		.btn_ok(btn_ok));
	keypad_unlock_and_clear_menu #(.DEBOUNCE(DEB_T), .HOLD(HOLD_T), .REPEAT(REPEAT_T)) dut (.*,
		.clear_outputs(), .clear_aux_relays(), .clear_states(), .clear_timers(), .clear_counters(),
		.clear_data_regs(), .clear_ext_regs(), .clear_inputs(), .clear_file_regs(),
		.clear_extended_file_registers());
	// clock
	initial forever #12.5 clk_sys = ~clk_sys;
	// cycle limit and clear pulse count
	always @(posedge clk_sys) begin
		cyc++;
		if (clear_pulse === 1'b1) pulses++;
		if (cyc == 60000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// press a button and compare the screen
	task automatic k(input int b, input screen_type s);
		op.push(b, 4);
		`CHK(screen, s)
	endtask
	// steps from a held button: one on press, one after the hold time, then one per repeat period
	function automatic int held_steps(input int n);
		int s;
		s = 1;
		for (int t = HOLD_T + DEB_T; t <= n + DEB_T - 1; t += REPEAT_T) s++;
		return s;
	endfunction
	// key in a code digit by digit, model digits in a queue
	task automatic enter(input int d, input logic [63:0] c);
		int v;
		q = {};
		for (int i = d - 1; i >= 0; i--) q.push_back(c[4*i+:4]);
		while (q.size() > 0) begin
			v = q.pop_front();
			op.push(2, 100);
			repeat (v) op.push(1, 4);
			`CHK(cursor_digit, v[3:0])
			op.push(0, 4);
		end
	endtask
	// main sequence: unlock paths then clear-all
	initial begin
		void'($urandom(59206));
		stored_code = {$urandom, $urandom};
		repeat (16) @(negedge clk_sys);
		nrst = 1'b1;
		k(0, SCR_MENU);
		k(0, SCR_NO_CODE);
		k(3, SCR_MENU);
		code_registered = 1'b1;
		k(0, SCR_CODE_ENTRY);
		`CHK(entry_lines, 2'h2)
		k(3, SCR_MENU);
		k(0, SCR_CODE_ENTRY);
		op.push(2, 4);
		`CHK(cursor_digit, 4'h0)
		op.push(1, 30);
		`CHK(cursor_digit, 4'(held_steps(30)))
		op.push(1, 120);
		`CHK(cursor_digit, 4'hF)
		op.push(2, 4);
		`CHK(cursor_digit, 4'hE)
		op.push(0, 4);
		`CHK(cursor_pos, 5'h01)
		op.push(3, 4);
		`CHK(cursor_pos, 5'h00)
		enter(16, stored_code ^ 64'h1);
		`CHK(screen, SCR_WRONG_MSG)
		`CHK(entered_code, stored_code ^ 64'h1)
		`CHK(lock_state, LOCK_ACTIVE)
		k(3, SCR_CODE_ENTRY);
		enter(16, stored_code);
		`CHK(screen, SCR_UNLOCKED_MSG)
		`CHK(lock_state, LOCK_CANCELLED)
		`CHK(entered_code, stored_code)
		k(3, SCR_MENU);
		k(0, SCR_REENABLE);
		k(1, SCR_REENABLE);
		k(3, SCR_MENU);
		`CHK(lock_state, LOCK_CANCELLED)
		k(0, SCR_REENABLE);
		k(0, SCR_MENU);
		`CHK(lock_state, LOCK_ACTIVE)
		code_is_16 = 1'b0;
		k(0, SCR_CODE_ENTRY);
		`CHK(entry_lines, 2'h1)
		enter(8, {32'h0, stored_code[31:0]});
		`CHK(screen, SCR_UNLOCKED_MSG)
		`CHK(entered_code, {stored_code[31:0], 32'h0})
		k(0, SCR_MENU);
		k(3, SCR_TOP);
		$display("unlock test done");
		k(0, SCR_MENU);
		menu_item = ITEM_OTHER;
		k(0, SCR_MENU);
		menu_item = ITEM_CLEAR;
		plc_running = 1'b1;
		k(0, SCR_CLEAR_ASK);
		k(3, SCR_MENU);
		k(0, SCR_CLEAR_ASK);
		k(0, SCR_RUNNING_MSG);
		`CHK(pulses, 0)
		k(3, SCR_MENU);
		plc_running = 1'b0;
		k(0, SCR_CLEAR_ASK);
		k(0, SCR_CLEAR_DONE);
		`CHK(pulses, 1)
		k(3, SCR_MENU);
		$display("clear test done");
		wrap_up();
	end
endmodule
`default_nettype wire
